// File: panel_host.sv
`timescale 1ns/10ps
// Host side of the command port
module panel_host
    import panel_pkg::*;
(
    input wire logic mclk,
    input wire logic [DATA_W-1:0] rdata,
    output logic [1:0] addr,
    output logic [DATA_W-1:0] wdata,
    output logic wr,
    output logic rd
);
    initial begin
        addr = 2'h3;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
    end

    // One write strobe, back to back until idle
    task automatic bus_wr(input logic [1:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        rd <= 1'b0;
        @(posedge mclk);
    endtask

    // Drop strobe, scramble released lines
    task automatic idle();
        wr <= 1'b0;
        addr <= ~addr;
        wdata <= ~wdata;
        @(posedge mclk);
    endtask

    // Command byte, then parameters in order
    task automatic send(input logic [7:0] c, input int n, input logic [7:0] p0, input logic [7:0] p1);
        bus_wr(ADDR_COMMAND, c);
        if (n > 0) bus_wr(ADDR_PARAM, p0);
        if (n > 1) bus_wr(ADDR_PARAM, p1);
        idle();
    endtask

    // Read strobe, data taken in the following cycle
    task automatic bus_rd(input logic [1:0] a, output logic [7:0] d);
        addr <= a;
        rd <= 1'b1;
        wr <= 1'b0;
        @(posedge mclk);
        rd <= 1'b0;
        addr <= ~a;
        @(negedge mclk);
        d = rdata;
        @(posedge mclk);
    endtask
endmodule

// File: panel_pkg.sv
package panel_pkg;

    localparam int DATA_W = 8;

    // Register port addresses
    localparam logic [1:0] ADDR_COMMAND = 2'h0;
    localparam logic [1:0] ADDR_PARAM = 2'h1;
    localparam logic [1:0] ADDR_STATUS = 2'h2;

    // Command codes
    localparam logic [7:0] CMD_INVERSION = 8'hB4;
    localparam logic [7:0] CMD_REFERENCE = 8'hB5;
    localparam logic [7:0] CMD_COMMON = 8'hB6;

    // Reset values
    localparam logic [7:0] INV_FIRST_RST = 8'h80;
    localparam logic [7:0] INV_SECOND_RST = 8'h00;
    localparam logic [7:0] REF_RST = 8'h09;
    localparam logic [7:0] COM_RST = 8'h4D;
    localparam logic [2:0] COUNT_RST = 3'h0;

    // Writable bit masks, other bits read as zero
    localparam logic [7:0] INV_FIRST_MASK = 8'hF7;
    localparam logic [7:0] INV_SECOND_MASK = 8'h37;
    localparam logic [7:0] REF_MASK = 8'h1F;

    // Field positions
    localparam int BIT_EXTRA_SOURCE = 7;
    localparam int BIT_ROW_SHIFT = 6;
    localparam int BIT_ZZ_ENABLE = 5;
    localparam int BIT_ZZ_VARIANT = 4;
    localparam int PAT_LSB = 0;
    localparam int PAT_W = 3;
    localparam int DELAY_LSB = 4;
    localparam int DELAY_W = 2;
    localparam int REF_W = 5;
    localparam int COUNT_W = 3;
    localparam logic [2:0] PATTERN_INVALID = 3'h7;
    localparam logic [2:0] COUNT_MAX = 3'h4;

    // Parameter byte positions
    localparam logic [1:0] IDX_FIRST = 2'h0;
    localparam logic [1:0] IDX_SECOND = 2'h1;
    localparam logic [1:0] IDX_THIRD = 2'h2;
    localparam logic [1:0] IDX_LAST = 2'h3;

    // Level maps, millivolts
    localparam int REF_BASE_MV = 3500;
    localparam int REF_MID_MV = 5000;
    localparam int REF_KNEE_MV = 5400;
    localparam int REF_COARSE_MV = 100;
    localparam int REF_FINE_MV = 50;
    localparam int REF_MID_CODE = 15;
    localparam int REF_KNEE_CODE = 19;
    localparam int MV_W = 13;
    localparam int COM_K1 = 12;
    localparam int COM_K2 = 22;
    localparam int COM_K3 = 157;
    localparam int COM_K4 = 209;
    localparam int COM_V1 = 300;
    localparam int COM_V2 = 450;
    localparam int COM_V3 = 1800;
    localparam int COM_V4 = 2580;

    typedef enum logic [3:0] {
        SEL_NONE = 4'b0001,
        SEL_INV = 4'b0010,
        SEL_REF = 4'b0100,
        SEL_COM = 4'b1000
    } cmd_sel_t;

endpackage

// File: panel_settings.sv
`timescale 1ns/10ps
// Behaviour
// R1: Command B4 then two bytes set the inversion control.
// R2: Extra-source bit set picks last source channel, clear picks first.
// R3: Row-shift bit set shifts odd rows, clear shifts even rows.
// R4: Zig-zag enable bit turns zig-zag inversion on or off.
// R5: Variant bit set picks second zig-zag variant, clear the first.
// R6: Eight zig-zag types decode from variant, source and row bits.
// R7: Normal pattern field in first byte low bits applies in normal mode.
// R8: Separate idle pattern; codes 0-6 are patterns, code 7 invalid.
// R9: Command B5 then positive and negative 5-bit reference codes.
// R10: Reference code maps monotonically, 0 to 3.5 V, F 5.0 V, 1F 6.0 V.
// R11: Command B6 then two common codes and one read-only byte.
// R12: Scan direction 0 uses forward code, 1 uses backward code.
// R13: Common code maps to falling level, 0 gives 0 V, 4D -1 V.
// R14: Read-only field reports programming count, 0 none, up to 4.
// R15: Bytes taken in order; unsent bytes keep earlier values.
module panel_settings
    import panel_pkg::*;
#(
    parameter int DW = DATA_W
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [1:0] addr,
    input wire logic [DW-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [DW-1:0] rdata,
    input wire logic idle_mode,
    input wire logic panel_scan_direction,
    input wire logic [COUNT_W-1:0] otp_program_count,
    output logic zigzag_enable,
    output logic zigzag_use_last_source,
    output logic zigzag_shift_odd_rows,
    output logic zigzag_second_variant,
    output logic [2:0] zigzag_type,
    output logic [PAT_W-1:0] active_inversion_pattern,
    output logic pattern_invalid,
    output logic [DELAY_W-1:0] amplifier_on_delay,
    output logic [MV_W-1:0] positive_ref_mv,
    output logic [MV_W-1:0] negative_ref_mv,
    output logic [MV_W-1:0] common_level_mv
);

    if (DW != DATA_W) begin : g_bad_width
        $error("panel_settings: data width must be 8");
    end

    cmd_sel_t sel_r, sel_nxt;
    logic [1:0] idx_r, idx_nxt;
    logic [7:0] inv_first_r, inv_first_nxt;
    logic [7:0] inv_second_r, inv_second_nxt;
    logic [7:0] pos_ref_r, pos_ref_nxt;
    logic [7:0] neg_ref_r, neg_ref_nxt;
    logic [7:0] com_fwd_r, com_fwd_nxt;
    logic [7:0] com_bwd_r, com_bwd_nxt;
    logic [COUNT_W-1:0] count_r, count_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic zz_en_r, zz_en_nxt;
    logic zz_src_r, zz_src_nxt;
    logic zz_row_r, zz_row_nxt;
    logic zz_var_r, zz_var_nxt;
    logic [2:0] zz_type_r, zz_type_nxt;
    logic [PAT_W-1:0] pat_r, pat_nxt;
    logic pat_bad_r, pat_bad_nxt;
    logic [DELAY_W-1:0] delay_r, delay_nxt;
    logic [MV_W-1:0] pos_mv_r, pos_mv_nxt;
    logic [MV_W-1:0] neg_mv_r, neg_mv_nxt;
    logic [MV_W-1:0] com_mv_r, com_mv_nxt;
    logic [7:0] com_sel;

    // Reference code to millivolts
    function automatic logic [MV_W-1:0] ref_mv(input logic [7:0] code);
        int c;
        int v;
        c = int'(code[REF_W-1:0]);
        if (c <= REF_MID_CODE) begin
            v = REF_BASE_MV + REF_COARSE_MV * c;
        end else if (c <= REF_KNEE_CODE) begin
            v = REF_MID_MV + REF_COARSE_MV * (c - REF_MID_CODE);
        end else begin
            v = REF_KNEE_MV + REF_FINE_MV * (c - REF_KNEE_CODE);
        end
        return MV_W'(v);
    endfunction

    // Common code to millivolts below ground
    function automatic logic [MV_W-1:0] com_mv(input logic [7:0] code);
        int c;
        int v;
        c = int'(code);
        if (c <= COM_K1) begin
            v = 25 * c;
        end else if (c <= COM_K2) begin
            v = COM_V1 + 15 * (c - COM_K1);
        end else if (c <= COM_K3) begin
            v = COM_V2 + 10 * (c - COM_K2);
        end else if (c <= COM_K4) begin
            v = COM_V3 + 15 * (c - COM_K3);
        end else begin
            v = COM_V4 + 20 * (c - COM_K4);
        end
        return MV_W'(v);
    endfunction

    // Parameter byte read back
    function automatic logic [7:0] param_byte(input cmd_sel_t s, input logic [1:0] i);
        logic [7:0] b;
        b = 8'h00;
        unique case (s)
            SEL_INV: b = (i == IDX_FIRST) ? inv_first_r : (i == IDX_SECOND) ? inv_second_r : 8'h00;
            SEL_REF: b = (i == IDX_FIRST) ? pos_ref_r : (i == IDX_SECOND) ? neg_ref_r : 8'h00;
            SEL_COM: begin
                if (i == IDX_FIRST) begin
                    b = com_fwd_r;
                end else if (i == IDX_SECOND) begin
                    b = com_bwd_r;
                end else if (i == IDX_THIRD) begin
                    b = {5'h00, count_r}; // see R14
                end
            end
            SEL_NONE: b = 8'h00;
        endcase
        return b;
    endfunction

    assign com_sel = panel_scan_direction ? com_bwd_r : com_fwd_r; // see R12

    // Command and parameter sequencing
    always_comb begin
        sel_nxt = sel_r;
        idx_nxt = idx_r;
        inv_first_nxt = inv_first_r;
        inv_second_nxt = inv_second_r;
        pos_ref_nxt = pos_ref_r;
        neg_ref_nxt = neg_ref_r;
        com_fwd_nxt = com_fwd_r;
        com_bwd_nxt = com_bwd_r;
        rdata_nxt = 8'h00;
        if (wr && addr == ADDR_COMMAND) begin
            idx_nxt = IDX_FIRST;
            unique case (wdata)
                CMD_INVERSION: sel_nxt = SEL_INV; // see R1
                CMD_REFERENCE: sel_nxt = SEL_REF; // see R9
                CMD_COMMON: sel_nxt = SEL_COM; // see R11
                default: sel_nxt = SEL_NONE;
            endcase
        end else if (wr && addr == ADDR_PARAM) begin
            // Only the byte at the current position changes
            unique case (sel_r)
                SEL_INV: begin
                    if (idx_r == IDX_FIRST) begin
                        inv_first_nxt = wdata & INV_FIRST_MASK; // see R1
                    end else if (idx_r == IDX_SECOND) begin
                        inv_second_nxt = wdata & INV_SECOND_MASK; // see R15
                    end
                end
                SEL_REF: begin
                    if (idx_r == IDX_FIRST) begin
                        pos_ref_nxt = wdata & REF_MASK; // see R9
                    end else if (idx_r == IDX_SECOND) begin
                        neg_ref_nxt = wdata & REF_MASK; // see R9
                    end
                end
                SEL_COM: begin
                    if (idx_r == IDX_FIRST) begin
                        com_fwd_nxt = wdata; // see R11
                    end else if (idx_r == IDX_SECOND) begin
                        com_bwd_nxt = wdata; // see R11
                    end
                end
                SEL_NONE: begin
                end
            endcase
            idx_nxt = (idx_r == IDX_LAST) ? idx_r : idx_r + 2'h1; // see R15
        end
        if (rd && addr == ADDR_PARAM) begin
            rdata_nxt = param_byte(sel_r, idx_r);
            idx_nxt = (idx_r == IDX_LAST) ? idx_r : idx_r + 2'h1;
        end else if (rd && addr == ADDR_STATUS) begin
            rdata_nxt = {pat_bad_r, zz_type_r, zz_en_r, pat_r};
        end
    end

    // Decoded settings
    always_comb begin
        count_nxt = (otp_program_count > COUNT_MAX) ? COUNT_MAX : otp_program_count; // see R14
        zz_src_nxt = inv_first_r[BIT_EXTRA_SOURCE]; // see R2
        zz_row_nxt = inv_first_r[BIT_ROW_SHIFT]; // see R3
        zz_en_nxt = inv_first_r[BIT_ZZ_ENABLE]; // see R4
        zz_var_nxt = inv_first_r[BIT_ZZ_VARIANT]; // see R5
        zz_type_nxt = {zz_var_nxt, zz_src_nxt, ~(zz_src_nxt ^ zz_row_nxt)}; // see R6
        if (idle_mode) begin
            pat_nxt = inv_second_r[PAT_LSB +: PAT_W]; // see R8
        end else begin
            pat_nxt = inv_first_r[PAT_LSB +: PAT_W]; // see R7
        end
        pat_bad_nxt = (pat_nxt == PATTERN_INVALID); // see R8
        delay_nxt = inv_second_r[DELAY_LSB +: DELAY_W];
        pos_mv_nxt = ref_mv(pos_ref_r); // see R10
        neg_mv_nxt = ref_mv(neg_ref_r); // see R10
        com_mv_nxt = com_mv(com_sel); // see R13
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sel_r <= SEL_NONE;
            idx_r <= IDX_FIRST;
            inv_first_r <= INV_FIRST_RST;
            inv_second_r <= INV_SECOND_RST;
            pos_ref_r <= REF_RST;
            neg_ref_r <= REF_RST;
            com_fwd_r <= COM_RST;
            com_bwd_r <= COM_RST;
            count_r <= COUNT_RST;
            rdata_r <= 8'h00;
            zz_en_r <= 1'b0;
            zz_src_r <= 1'b0;
            zz_row_r <= 1'b0;
            zz_var_r <= 1'b0;
            zz_type_r <= 3'h0;
            pat_r <= 3'h0;
            pat_bad_r <= 1'b0;
            delay_r <= 2'h0;
            pos_mv_r <= 13'h0000;
            neg_mv_r <= 13'h0000;
            com_mv_r <= 13'h0000;
        end else begin
            sel_r <= sel_nxt;
            idx_r <= idx_nxt;
            inv_first_r <= inv_first_nxt;
            inv_second_r <= inv_second_nxt;
            pos_ref_r <= pos_ref_nxt;
            neg_ref_r <= neg_ref_nxt;
            com_fwd_r <= com_fwd_nxt;
            com_bwd_r <= com_bwd_nxt;
            count_r <= count_nxt;
            rdata_r <= rdata_nxt;
            zz_en_r <= zz_en_nxt;
            zz_src_r <= zz_src_nxt;
            zz_row_r <= zz_row_nxt;
            zz_var_r <= zz_var_nxt;
            zz_type_r <= zz_type_nxt;
            pat_r <= pat_nxt;
            pat_bad_r <= pat_bad_nxt;
            delay_r <= delay_nxt;
            pos_mv_r <= pos_mv_nxt;
            neg_mv_r <= neg_mv_nxt;
            com_mv_r <= com_mv_nxt;
        end
    end

    assign rdata = rdata_r;
    assign zigzag_enable = zz_en_r;
    assign zigzag_use_last_source = zz_src_r;
    assign zigzag_shift_odd_rows = zz_row_r;
    assign zigzag_second_variant = zz_var_r;
    assign zigzag_type = zz_type_r;
    assign active_inversion_pattern = pat_r;
    assign pattern_invalid = pat_bad_r;
    assign amplifier_on_delay = delay_r;
    assign positive_ref_mv = pos_mv_r;
    assign negative_ref_mv = neg_mv_r;
    assign common_level_mv = com_mv_r;

    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);

    chk_cmd_inv_select: assert property (wr && addr == ADDR_COMMAND && wdata == CMD_INVERSION |=> // see R1
        sel_r == SEL_INV && idx_r == IDX_FIRST) else $error("inversion command not selected");
    chk_inv_first_store: assert property (wr && addr == ADDR_PARAM && sel_r == SEL_INV && idx_r == IDX_FIRST // see R1
        |=> inv_first_r == ($past(wdata) & INV_FIRST_MASK) ##1 zigzag_enable == inv_first_r[BIT_ZZ_ENABLE])
        else $error("inversion first byte not applied");
    chk_zigzag_type: assert property (rst_n |=> zigzag_type == {$past(inv_first_r[4]), // see R6
        $past(inv_first_r[7]), ~($past(inv_first_r[7]) ^ $past(inv_first_r[6]))}) else $error("zig-zag type wrong");
    chk_source_row_bits: assert property (rst_n |=> zigzag_use_last_source == $past(inv_first_r[7]) // see R2
        && zigzag_shift_odd_rows == $past(inv_first_r[6])) else $error("source or row bit wrong");
    chk_pattern_mode: assert property (rst_n |=> active_inversion_pattern == ($past(idle_mode) ? // see R7
        $past(inv_second_r[2:0]) : $past(inv_first_r[2:0]))) else $error("pattern mode select wrong");
    chk_pattern_invalid: assert property (pattern_invalid == (active_inversion_pattern == 3'h7)) // see R8
        else $error("invalid pattern flag wrong");
    chk_ref_level: assert property (pos_ref_r == 8'h0F ##1 pos_ref_r == 8'h0F |-> positive_ref_mv == 13'd5000) // see R10
        else $error("reference level wrong");
    chk_com_direction: assert property (panel_scan_direction && com_bwd_r == 8'h4D |=> // see R12
        common_level_mv == 13'd1000) else $error("common level direction or map wrong");
    chk_com_zero: assert property (!panel_scan_direction && com_fwd_r == 8'h00 |=> // see R13
        common_level_mv == 13'd0) else $error("common zero level wrong");
    chk_count_range: assert property (count_r <= COUNT_MAX) else $error("program count above four"); // see R14
    chk_count_sat: assert property (otp_program_count > COUNT_MAX |=> count_r == COUNT_MAX) // see R14
        else $error("program count not saturated");
    chk_keep_unsent: assert property (wr && addr == ADDR_COMMAND |=> // see R15
        $stable(inv_first_r) && $stable(pos_ref_r) && $stable(com_fwd_r)) else $error("unsent byte changed");

    cov_inv_write: cover property (wr && addr == ADDR_COMMAND && wdata == CMD_INVERSION ##1 wr && addr == ADDR_PARAM);
    cov_ref_write: cover property (sel_r == SEL_REF && idx_r == IDX_SECOND && wr && addr == ADDR_PARAM);
    cov_com_read: cover property (rd && addr == ADDR_PARAM && sel_r == SEL_COM && idx_r == IDX_THIRD);
    cov_idle_pat: cover property (idle_mode && pattern_invalid);

endmodule

// File: panel_settings_tb.sv
`timescale 1ns/10ps
module panel_settings_tb
    import panel_pkg::*;
;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [1:0] addr;
    logic [7:0] wdata, rdata, d, p;
    logic wr, rd, zz_en, zz_last, zz_odd, zz_var, pat_inv;
    logic idle_mode = 1'b0;
    logic panel_scan_direction = 1'b0;
    logic [2:0] otp_program_count = 3'h0;
    logic [2:0] zz_type, pat;
    logic [1:0] amp_dly;
    logic [12:0] pos_mv, neg_mv, com_mv;
    logic [7:0] rc [5] = '{8'h00, 8'h0f, 8'h1f, 8'h13, 8'h14};
    logic [12:0] rv [5] = '{13'h0dac, 13'h1388, 13'h1770, 13'h1518, 13'h154a};
    logic [7:0] cc [10] = '{8'h00, 8'h01, 8'h0c, 8'h0d, 8'h16, 8'h17, 8'h4d, 8'h9e, 8'ha0, 8'hff};
    logic [12:0] cv [10] = '{13'h0000, 13'h0019, 13'h012c, 13'h013b, 13'h01c2, 13'h01cc, 13'h03e8,
        13'h0717, 13'h0735, 13'h0dac};
    int mismatches = 0;
    int n_tests = 0;

    always #25 mclk = ~mclk;

    panel_settings dut_u (.mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .idle_mode(idle_mode), .panel_scan_direction(panel_scan_direction),
        .otp_program_count(otp_program_count), .zigzag_enable(zz_en), .zigzag_use_last_source(zz_last),
        .zigzag_shift_odd_rows(zz_odd), .zigzag_second_variant(zz_var), .zigzag_type(zz_type),
        .active_inversion_pattern(pat), .pattern_invalid(pat_inv), .amplifier_on_delay(amp_dly),
        .positive_ref_mv(pos_mv), .negative_ref_mv(neg_mv), .common_level_mv(com_mv));

    panel_host host_u (.mclk(mclk), .rdata(rdata), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: byte %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_mv(input logic [12:0] got, input logic [12:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: level %0d expected %0d", $time, got, exp);
        end
    endtask

    task automatic settle();
        repeat (2) @(posedge mclk);
        #1;
    endtask

    // Command, then two parameter reads right behind it
    task automatic rd_back(input logic [7:0] c, input logic [7:0] e0, input logic [7:0] e1);
        host_u.bus_wr(ADDR_COMMAND, c);
        host_u.bus_rd(ADDR_PARAM, d);
        chk_byte(d, e0);
        host_u.bus_rd(ADDR_PARAM, d);
        chk_byte(d, e1);
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge mclk);
        mismatches++;
        $display("wrong value at %0t: watchdog expired", $time);
        end_of_test();
    end

    initial begin
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        settle();
        chk_byte({zz_var, zz_last, zz_odd, zz_en, pat_inv, pat}, 8'h40);
        chk_byte({5'h00, zz_type}, 8'h02);
        chk_mv(pos_mv, 13'h1130);
        chk_mv(com_mv, 13'h03e8);
        rd_back(CMD_INVERSION, INV_FIRST_RST, INV_SECOND_RST);
        rd_back(CMD_REFERENCE, REF_RST, REF_RST);
        rd_back(CMD_COMMON, COM_RST, COM_RST);
        $display("test reset done");
        // Every zig-zag combination, reserved bit 3 set
        for (int i = 0; i < 8; i++) begin
            p = {i[1], ~(i[0] ^ i[1]), i[0], i[2], 1'b1, i[2:0]};
            host_u.send(CMD_INVERSION, 1, p, 8'h00);
            settle();
            chk_byte({zz_var, zz_last, zz_odd, zz_en, pat_inv, pat}, {p[4], p[7:5], (i == 7), p[2:0]});
            chk_byte({5'h00, zz_type}, 8'(i));
            host_u.bus_rd(ADDR_STATUS, d);
            chk_byte(d, {(i == 7), 3'(i), p[5], p[2:0]});
            rd_back(CMD_INVERSION, p & 8'hf7, 8'h00);
        end
        $display("test zigzag done");
        host_u.send(CMD_INVERSION, 2, 8'h02, 8'hfd);
        idle_mode <= 1'b1;
        settle();
        chk_byte({6'h00, amp_dly}, 8'h03);
        chk_byte({5'h00, pat}, 8'h05);
        idle_mode <= 1'b0;
        settle();
        chk_byte({5'h00, pat}, 8'h02);
        host_u.send(CMD_INVERSION, 1, 8'h06, 8'h00);
        rd_back(CMD_INVERSION, 8'h06, 8'h35);
        $display("test idle done");
        for (int k = 0; k < 5; k++) begin
            host_u.send(CMD_REFERENCE, 2, rc[k] | 8'he0, rc[4-k]);
            settle();
            chk_mv(pos_mv, rv[k]);
            chk_mv(neg_mv, rv[4-k]);
        end
        host_u.send(CMD_REFERENCE, 1, 8'h0f, 8'h00);
        settle();
        chk_mv(pos_mv, rv[1]);
        chk_mv(neg_mv, rv[0]);
        rd_back(CMD_REFERENCE, 8'h0f, 8'h00);
        // Unknown command, status and unmapped writes change nothing
        host_u.bus_wr(ADDR_COMMAND, 8'h00);
        host_u.bus_wr(ADDR_PARAM, 8'h1f);
        host_u.bus_wr(ADDR_STATUS, 8'hff);
        host_u.bus_wr(2'h3, 8'hff);
        host_u.idle();
        settle();
        chk_mv(pos_mv, rv[1]);
        host_u.bus_rd(2'h3, d);
        chk_byte(d, 8'h00);
        @(negedge mclk);
        chk_byte(rdata, 8'h00);
        @(posedge mclk);
        $display("test reference done");
        for (int k = 0; k < 10; k++) begin
            host_u.send(CMD_COMMON, 2, cc[k], cc[9-k]);
            panel_scan_direction <= 1'b0;
            settle();
            chk_mv(com_mv, cv[k]);
            panel_scan_direction <= 1'b1;
            settle();
            chk_mv(com_mv, cv[9-k]);
        end
        $display("test common done");
        // Third byte is read-only
        host_u.bus_wr(ADDR_COMMAND, CMD_COMMON);
        host_u.bus_wr(ADDR_PARAM, 8'h11);
        host_u.bus_wr(ADDR_PARAM, 8'h22);
        host_u.bus_wr(ADDR_PARAM, 8'hff);
        host_u.idle();
        for (int c = 0; c < 6; c++) begin
            otp_program_count <= 3'(c);
            settle();
            rd_back(CMD_COMMON, 8'h11, 8'h22);
            host_u.bus_rd(ADDR_PARAM, d);
            chk_byte(d, (c > 4) ? {5'h00, COUNT_MAX} : 8'(c));
        end
        $display("test count done");
        end_of_test();
    end
endmodule
